// ---- design/csb_pkg.sv ----
/*
 Constants and types for the processor status and bank-select block.
 Assumes an AHB-Lite master with word accesses and a core on the same clock.
*/
package csb_pkg;
  localparam int DATA_W = 8;
  // status bit positions
  localparam int IRP_BIT = 7;
  localparam int RP_HI = 6;
  localparam int RP_LO = 5;
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;
  localparam int Z_BIT = 2;
  localparam int DC_BIT = 1;
  localparam int C_BIT = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] PTR_RST = 8'h00;
  // register indices as printed, byte address is four times the index
  localparam logic [11:0] STATUS_IDX = 12'h183;
  localparam logic [11:0] PTR_IDX = 12'h184;
  localparam logic [11:0] ADDR_STATUS = {STATUS_IDX[9:0], 2'b00};
  localparam logic [11:0] ADDR_PTR = {PTR_IDX[9:0], 2'b00};
  localparam logic [11:0] ADDR_EVT = 12'h000;
  localparam logic [11:0] ADDR_EVTCLR = 12'h004;
  localparam logic [11:0] ADDR_EVTEN = 12'h008;
  // event bits
  localparam int EVT_W = 3;
  localparam int EVT_WDT = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_ROWR = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  // offsets within a bank that reach the same register in every bank
  localparam int NCOMMON = 6;
  localparam logic [6:0] COMMON_OFS [NCOMMON] =
    '{7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B};
  typedef enum logic [3:0] {
    OP_NONE, OP_MOVE, OP_CLEAR, OP_ADD, OP_SUB,
    OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC
  } csb_op_t;
  typedef enum logic [1:0] {DEST_NONE, DEST_STATUS, DEST_PTR} csb_dest_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_LAST} csb_bus_t;
  typedef enum logic [2:0] {
    REG_NONE, REG_STATUS, REG_PTR, REG_EVT, REG_EVTCLR, REG_EVTEN
  } csb_reg_t;
endpackage : csb_pkg

// ---- design/csb_alu_if.sv ----
/*
 Operation request and flag answer between the status block and its ALU.
 Assumes both ends sit on one clock; the answer is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface csb_alu_if;
  import csb_pkg::*;
  csb_op_t op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic cin;
  logic [DATA_W-1:0] result;
  logic zero;
  logic digitCarry;
  logic carry;
  logic setsZ;
  logic setsDc;
  logic setsC;
  modport core(output op, a, b, cin,
    input result, zero, digitCarry, carry, setsZ, setsDc, setsC);
  modport alu(input op, a, b, cin,
    output result, zero, digitCarry, carry, setsZ, setsDc, setsC);
endinterface : csb_alu_if
`default_nettype wire

// ---- design/csb_flag_alu.sv ----
/*
 Byte ALU that forms the result and the zero, digit-carry and carry flags.
 Assumes the caller applies the flags only where the set signals say so.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_flag_alu (
  csb_alu_if.alu bus // operation in, result and flags out
);
  import csb_pkg::*;
  logic [4:0] lowSum;
  logic [8:0] fullSum;
  logic [DATA_W-1:0] opB;
  always_comb begin
    // subtraction adds the two's complement, so carries mean no borrow
    opB = (bus.op == OP_SUB) ? ~bus.b : bus.b;
    lowSum = {1'b0, bus.a[3:0]} + {1'b0, opB[3:0]} + {4'h0, bus.op == OP_SUB};
    fullSum = {1'b0, bus.a} + {1'b0, opB} + {8'h00, bus.op == OP_SUB};
    bus.result = bus.b;
    bus.digitCarry = lowSum[4];
    bus.carry = fullSum[8];
    bus.setsZ = 1'b0;
    bus.setsDc = 1'b0;
    bus.setsC = 1'b0;
    case (bus.op)
      OP_CLEAR: begin
        bus.result = 8'h00;
        bus.setsZ = 1'b1;
      end
      OP_ADD, OP_SUB: begin
        bus.result = fullSum[7:0];
        bus.setsZ = 1'b1;
        bus.setsDc = 1'b1;
        bus.setsC = 1'b1;
      end
      OP_AND: begin
        bus.result = bus.a & bus.b;
        bus.setsZ = 1'b1;
      end
      OP_OR: begin
        bus.result = bus.a | bus.b;
        bus.setsZ = 1'b1;
      end
      OP_XOR: begin
        bus.result = bus.a ^ bus.b;
        bus.setsZ = 1'b1;
      end
      OP_RLC: begin
        bus.result = {bus.a[6:0], bus.cin};
        bus.carry = bus.a[7];
        bus.setsC = 1'b1;
      end
      OP_RRC: begin
        bus.result = {bus.cin, bus.a[7:1]};
        bus.carry = bus.a[0];
        bus.setsC = 1'b1;
      end
      default: bus.result = bus.b;
    endcase
    bus.zero = (bus.result == 8'h00);
  end
endmodule : csb_flag_alu
`default_nettype wire

// ---- design/csb_bank_map.sv ----
/*
 Forms direct and indirect data addresses from the bank bits.
 Assumes offsets come from core logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_bank_map (
  input wire logic [7:0] status, // current status byte
  input wire logic [7:0] pointer, // indirect pointer
  input wire logic [6:0] directOfs, // direct offset in bank
  output logic [8:0] directAddr, // full direct address
  output logic [8:0] indirectAddr, // full indirect address
  output logic directCommon, // direct access hits a shared register
  output logic indirectCommon // indirect access hits a shared register
);
  import csb_pkg::*;
  function automatic logic isCommon(input logic [6:0] ofs);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NCOMMON; i++) begin
      hit = hit | (ofs == COMMON_OFS[i]);
    end
    return hit;
  endfunction : isCommon
  assign directAddr = {status[RP_HI:RP_LO], directOfs};
  assign indirectAddr = {status[IRP_BIT], pointer};
  // shared registers answer at the same offset in every bank
  assign directCommon = isCommon(directOfs);
  assign indirectCommon = isCommon(pointer[6:0]);
endmodule : csb_bank_map
`default_nettype wire

// ---- design/csb_status_bank.sv ----
/*
 Processor status register with bank selection, indirect pointer, event
 flags and an AHB-Lite slave. Assumes the core, the watchdog and the bus
 all run on mclk; core strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_status_bank (
  input wire logic mclk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic coreOpValid, // core op strobe
  input wire csb_pkg::csb_op_t coreOp, // operation
  input wire csb_pkg::csb_dest_t coreDest, // where the result goes
  input wire logic [7:0] coreA, // first operand
  input wire logic [7:0] coreB, // second operand
  input wire logic coreKick, // watchdog kick strobe
  input wire logic coreSleep, // sleep strobe
  input wire logic wdtTimeout, // watchdog expiry strobe
  input wire logic [6:0] directOfs, // direct offset in bank
  output logic [7:0] coreResult, // last op result
  output logic [7:0] statusOut, // status byte
  output logic [8:0] directAddr, // registered direct address
  output logic [8:0] indirectAddr, // registered indirect address
  output logic directCommon, // direct hits shared register
  output logic indirectCommon, // indirect hits shared register
  output logic irq // level interrupt
);
  import csb_pkg::*;

  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  // sticky event flags and their interrupt enables
  logic [EVT_W-1:0] evtStatus;
  logic [EVT_W-1:0] evtEnable;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;
  logic [EVT_W-1:0] next_evt;
  csb_bus_t busState;
  csb_reg_t busReg;
  logic addrAccept;
  logic wrStatus;
  logic wrPtr;
  logic wrEvtClr;
  logic wrEvtEn;
  logic [7:0] wrByte;
  logic [7:0] readByte;
  logic coreToStatus;
  logic coreToPtr;
  logic flagOp;
  logic roAttempt;
  logic [8:0] mapDirect;
  logic [8:0] mapIndirect;
  logic mapDirCommon;
  logic mapIndCommon;

  // the ALU hangs off its own interface so the flag rules stay in one place
  csb_alu_if aluBus();

  csb_flag_alu u_alu (
    .bus(aluBus.alu)
  );

  csb_bank_map u_map (
    .status(status),
    .pointer(pointer),
    .directOfs(directOfs),
    .directAddr(mapDirect),
    .indirectAddr(mapIndirect),
    .directCommon(mapDirCommon),
    .indirectCommon(mapIndCommon)
  );

  // only the lowest 4K bytes decode; higher addresses read zero, drop writes
  function automatic csb_reg_t decodeReg(input logic [31:0] addr);
    csb_reg_t sel;
    sel = REG_NONE;
    if (addr[31:12] == 20'h00000) begin
      case (addr[11:0])
        ADDR_STATUS: sel = REG_STATUS;
        ADDR_PTR: sel = REG_PTR;
        ADDR_EVT: sel = REG_EVT;
        ADDR_EVTCLR: sel = REG_EVTCLR;
        ADDR_EVTEN: sel = REG_EVTEN;
        default: sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction : decodeReg

  // core operation into the ALU; idle ops keep the flags still
  assign aluBus.op = coreOpValid ? coreOp : OP_NONE;
  assign aluBus.a = coreA;
  assign aluBus.b = coreB;
  assign aluBus.cin = status[C_BIT];

  // hsize is not decoded: every access is taken as a whole word
  assign addrAccept = hsel & hready & htrans[1];
  assign wrByte = hwdata[7:0];
  assign wrStatus = (busState == BUS_WR) && (busReg == REG_STATUS);
  assign wrPtr = (busState == BUS_WR) && (busReg == REG_PTR);
  assign wrEvtClr = (busState == BUS_WR) && (busReg == REG_EVTCLR);
  assign wrEvtEn = (busState == BUS_WR) && (busReg == REG_EVTEN);
  // the core strobe qualifies its destination so idle cycles write nothing
  assign coreToStatus = coreOpValid && (coreDest == DEST_STATUS);
  assign coreToPtr = coreOpValid && (coreDest == DEST_PTR);
  assign flagOp = aluBus.setsZ | aluBus.setsDc | aluBus.setsC;

  // bus phase tracking; reads take one wait state so that a read right
  // after a write sees the written value
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busState <= BUS_IDLE;
      busReg <= REG_NONE;
    end else begin
      case (busState)
        BUS_RD_WAIT: busState <= BUS_RD_LAST;
        BUS_IDLE, BUS_WR, BUS_RD_LAST: begin
          if (addrAccept) begin
            busState <= hwrite ? BUS_WR : BUS_RD_WAIT;
            busReg <= decodeReg(haddr);
          end else begin
            busState <= BUS_IDLE;
          end
        end
        default: busState <= BUS_IDLE;
      endcase
    end
  end

  // writes never wait; each read waits exactly one cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
    end else if (addrAccept && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (busState == BUS_RD_WAIT) begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // the clear register is write-only and reads back zero
  always_comb begin
    case (busReg)
      REG_STATUS: readByte = status;
      REG_PTR: readByte = pointer;
      REG_EVT: readByte = {{(8 - EVT_W){1'b0}}, evtStatus};
      REG_EVTEN: readByte = {{(8 - EVT_W){1'b0}}, evtEnable};
      default: readByte = 8'h00;
    endcase
  end

  // read data is caught in the wait cycle and held until the next read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (busState == BUS_RD_WAIT) begin
      hrdata <= {24'h000000, readByte};
    end
  end

  // a bus write acts like a plain move: flags untouched by any ALU effect
  always_comb begin
    next_status = status;
    if (wrStatus) begin
      next_status[IRP_BIT:RP_LO] = wrByte[IRP_BIT:RP_LO];
      next_status[Z_BIT:C_BIT] = wrByte[Z_BIT:C_BIT];
    end
    // the core wins over a bus write landing in the same cycle
    if (coreToStatus) begin
      // bank bits take the result even when the op sets flags
      next_status[IRP_BIT:RP_LO] = aluBus.result[IRP_BIT:RP_LO];
      if (!flagOp) begin
        next_status[Z_BIT:C_BIT] = aluBus.result[Z_BIT:C_BIT];
      end
    end
    if (aluBus.setsZ) begin
      next_status[Z_BIT] = aluBus.zero;
    end
    if (aluBus.setsDc) begin
      next_status[DC_BIT] = aluBus.digitCarry;
    end
    if (aluBus.setsC) begin
      next_status[C_BIT] = aluBus.carry;
    end
    // power flags move only on their own events, never on a write
    if (coreKick) begin
      next_status[TO_BIT] = 1'b1;
      next_status[PD_BIT] = 1'b1;
    end
    if (coreSleep) begin
      next_status[TO_BIT] = 1'b1;
      next_status[PD_BIT] = 1'b0;
    end
    // expiry wins over a kick in the same cycle: the timeout really happened
    if (wdtTimeout) begin
      next_status[TO_BIT] = 1'b0;
    end
  end

  // arithmetic flags come up zero although software may not rely on them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // the core wins over the bus for the pointer too
  always_comb begin
    next_pointer = pointer;
    if (wrPtr) begin
      next_pointer = wrByte;
    end
    if (coreToPtr) begin
      next_pointer = aluBus.result;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pointer <= PTR_RST;
    end else begin
      pointer <= next_pointer;
    end
  end

  // the last result stays for the core to read back; idle cycles hold it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      coreResult <= 8'h00;
    end else if (coreOpValid) begin
      coreResult <= aluBus.result;
    end
  end

  // an attempt to change a power flag by writing is reported, not obeyed
  always_comb begin
    roAttempt = 1'b0;
    if (wrStatus && (wrByte[TO_BIT:PD_BIT] != status[TO_BIT:PD_BIT])) begin
      roAttempt = 1'b1;
    end
    // a core write with no flag effect may also try to move them
    if (coreToStatus && !flagOp &&
        (aluBus.result[TO_BIT:PD_BIT] != status[TO_BIT:PD_BIT])) begin
      roAttempt = 1'b1;
    end
  end

  // event sources: watchdog expiry, sleep entry, refused power-flag write
  always_comb begin
    evtSet = '0;
    evtSet[EVT_WDT] = wdtTimeout;
    evtSet[EVT_SLEEP] = coreSleep;
    evtSet[EVT_ROWR] = roAttempt;
    evtClr = wrEvtClr ? wrByte[EVT_W-1:0] : '0;
    // a new event beats a clear in the same cycle
    next_evt = (evtStatus & ~evtClr) | evtSet;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      evtStatus <= EVT_RST;
    end else begin
      evtStatus <= next_evt;
    end
  end

  // a masked event still latches; the enable only gates the interrupt
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      evtEnable <= EVT_RST;
    end else if (wrEvtEn) begin
      evtEnable <= wrByte[EVT_W-1:0];
    end
  end

  // irq looks at next_evt so it rises on the same edge as the event bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evt & evtEnable);
    end
  end

  // addresses are registered so every output leaves a flip-flop; they lag
  // the bank bits by one cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      directAddr <= 9'h000;
      indirectAddr <= 9'h000;
      directCommon <= 1'b0;
      indirectCommon <= 1'b0;
    end else begin
      directAddr <= mapDirect;
      indirectAddr <= mapIndirect;
      directCommon <= mapDirCommon;
      indirectCommon <= mapIndCommon;
    end
  end

  // the status flop drives the port directly
  assign statusOut = status;

endmodule : csb_status_bank
`default_nettype wire

// ---- test/csb_status_bank_properties.sv ----
/*
 Checker for the status and bank-select block, watching its top ports only.
 Assumes one clock domain and the designer's bus and core timing.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_status_bank_props
  import csb_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic resetn, // async reset, active low
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic coreOpValid, // op strobe
  input wire csb_pkg::csb_op_t coreOp, // operation
  input wire csb_pkg::csb_dest_t coreDest, // destination
  input wire logic [7:0] coreA, // first operand
  input wire logic [7:0] coreB, // second operand
  input wire logic coreKick, // kick strobe
  input wire logic coreSleep, // sleep strobe
  input wire logic wdtTimeout, // expiry strobe
  input wire logic [6:0] directOfs, // direct offset
  input wire logic [7:0] statusOut, // status byte
  input wire logic [8:0] directAddr // direct address
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [8:0] sum;
  logic [8:0] diff;
  logic [4:0] sumNib;
  logic [4:0] diffNib;
  logic [2:0] addFlags;
  logic [2:0] subFlags;
  // subtract is modelled as add of the two's complement
  assign sum = {1'b0, coreA} + {1'b0, coreB};
  assign diff = {1'b0, coreA} + {1'b0, ~coreB} + 9'h001;
  assign sumNib = {1'b0, coreA[3:0]} + {1'b0, coreB[3:0]};
  assign diffNib = {1'b0, coreA[3:0]} + {1'b0, ~coreB[3:0]} + 5'h01;
  assign addFlags = {sum[7:0] == 8'h00, sumNib[4], sum[8]};
  assign subFlags = {diff[7:0] == 8'h00, diffNib[4], diff[8]};
  add_flags_a: assert property (
    coreOpValid && coreOp == OP_ADD && coreDest == DEST_NONE
    |=> statusOut[2:0] == $past(addFlags)) else $error("add flags wrong");
  sub_borrow_a: assert property (
    coreOpValid && coreOp == OP_SUB && coreDest == DEST_NONE
    |=> statusOut[2:0] == $past(subFlags)) else $error("subtract flags wrong");
  clear_status_a: assert property (
    coreOpValid && coreOp == OP_CLEAR && coreDest == DEST_STATUS
    |=> statusOut[7:5] == 3'b000 && statusOut[2] && $stable(statusOut[1:0])
    && $stable(statusOut[4:3])) else $error("clear of status wrong");
  kick_sets_a: assert property (
    coreKick && !coreSleep && !wdtTimeout |=> statusOut[4:3] == 2'b11)
    else $error("kick did not set power flags");
  sleep_flags_a: assert property (
    coreSleep && !wdtTimeout |=> statusOut[4:3] == 2'b10)
    else $error("sleep flags wrong");
  timeout_clears_a: assert property (
    wdtTimeout |=> !statusOut[4]) else $error("timeout did not clear flag");
  power_hold_a: assert property (
    !coreKick && !coreSleep && !wdtTimeout |=> $stable(statusOut[4:3]))
    else $error("power flags changed without event");
  direct_addr_a: assert property (
    $past(resetn) |-> directAddr == {$past(statusOut[6:5]), $past(directOfs)})
    else $error("direct address wrong");
  read_wait_a: assert property ( // bus wait state
    !hreadyout |=> hreadyout) else $error("wait state too long");
  resp_okay_a: assert property ( // bus response
    hresp == 1'b0) else $error("response not okay");
endmodule : csb_status_bank_props
bind csb_status_bank csb_status_bank_props csb_status_bank_props_i (
  .mclk(mclk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
  .coreOpValid(coreOpValid), .coreOp(coreOp), .coreDest(coreDest),
  .coreA(coreA), .coreB(coreB), .coreKick(coreKick), .coreSleep(coreSleep),
  .wdtTimeout(wdtTimeout), .directOfs(directOfs), .statusOut(statusOut),
  .directAddr(directAddr));
`default_nettype wire

// ---- test/csb_status_bank_bench.sv ----
/*
 Self-checking bench for the status and bank-select block.
 Assumes the bench acts as sole AHB-Lite master and as the core.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_status_bank_bench;
  import csb_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hready, hreadyout, hresp, irq, directCommon, indirectCommon;
  logic coreOpValid = 1'b0;
  logic coreKick = 1'b0;
  logic coreSleep = 1'b0;
  logic wdtTimeout = 1'b0;
  csb_op_t coreOp = OP_NONE;
  csb_dest_t coreDest = DEST_NONE;
  logic [7:0] coreA = 8'h00;
  logic [7:0] coreB = 8'h00;
  logic [7:0] coreResult, statusOut;
  logic [6:0] directOfs = 7'h00;
  logic [8:0] directAddr, indirectAddr;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  csb_op_t ops [12] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB, OP_AND, OP_RRC,
    OP_RLC, OP_OR, OP_XOR, OP_MOVE, OP_NONE};
  logic [7:0] opA [12] = '{8'h0F, 8'hFF, 8'h05, 8'h00, 8'h10, 8'hF0, 8'h02, 8'h80,
    8'h00, 8'hAA, 8'h00, 8'h00};
  logic [7:0] opB [12] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'h0F, 8'h02, 8'h80,
    8'h01, 8'hAA, 8'h3C, 8'h00};
  logic [7:0] expRes [12] = '{8'h10, 8'h00, 8'h00, 8'hFF, 8'h0F, 8'h00, 8'h81, 8'h00,
    8'h01, 8'h00, 8'h3C, 8'h3C};
  logic [2:0] expFlg [12] = '{3'b010, 3'b111, 3'b111, 3'b000, 3'b001, 3'b101, 3'b100,
    3'b101, 3'b001, 3'b101, 3'b101, 3'b101};
  assign hready = hreadyout;
  always #25 mclk = ~mclk;
  csb_status_bank csb_status_bank_i (
    .mclk(mclk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .coreOpValid(coreOpValid),
    .coreOp(coreOp), .coreDest(coreDest), .coreA(coreA), .coreB(coreB),
    .coreKick(coreKick), .coreSleep(coreSleep), .wdtTimeout(wdtTimeout),
    .directOfs(directOfs), .coreResult(coreResult), .statusOut(statusOut),
    .directAddr(directAddr), .indirectAddr(indirectAddr), .directCommon(directCommon),
    .indirectCommon(indirectCommon), .irq(irq));
  task print_verdict;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // master waits on hready without assuming any latency; the timeout ends a hang
  task ahb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : ahb
  task core(input csb_op_t op, input csb_dest_t dst, input logic [7:0] a,
    input logic [7:0] b);
    @(posedge mclk);
    coreOpValid <= 1'b1;
    coreOp <= op;
    coreDest <= dst;
    coreA <= a;
    coreB <= b;
    @(posedge mclk);
    coreOpValid <= 1'b0;
    #1;
  endtask : core
  task pulse(input logic [2:0] p);
    @(posedge mclk);
    {coreKick, coreSleep, wdtTimeout} <= p;
    @(posedge mclk);
    {coreKick, coreSleep, wdtTimeout} <= 3'b000;
    #1;
  endtask : pulse
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    tick(4);
    resetn <= 1'b1;
    chk("status at reset", {24'h0, STATUS_RST}, {24'h0, statusOut});
    ahb(ADDR_STATUS, 1'b0, 8'h00);
    chk("status read", 32'h00000018, rd);
    ahb(ADDR_PTR, 1'b0, 8'h00);
    chk("pointer read", {24'h0, PTR_RST}, rd);
    ahb(ADDR_STATUS, 1'b1, 8'hE5);
    chk("power bits kept", 32'hFD, {24'h0, statusOut});
    ahb(ADDR_EVT, 1'b0, 8'h00);
    chk("event after attempt", 32'h4, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(ADDR_EVTEN, 1'b1, 8'h07);
    ahb(ADDR_EVTEN, 1'b0, 8'h00);
    chk("enable read", 32'h7, rd);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(ADDR_EVTCLR, 1'b1, 8'h04);
    ahb(ADDR_EVTCLR, 1'b0, 8'h00);
    chk("clear reg read", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ahb(12'h100, 1'b0, 8'h00);
    chk("unmapped read", 32'h0, rd);
    directOfs <= 7'h0A;
    for (int i = 0; i < 4; i++) begin
      ahb(ADDR_STATUS, 1'b1, {1'b0, i[1:0], 5'h1D});
      tick(2);
      chk("direct address", {23'h0, i[1:0], 7'h0A}, {23'h0, directAddr});
      chk("direct shared", 32'h1, {31'h0, directCommon});
    end
    directOfs <= 7'h05;
    ahb(ADDR_PTR, 1'b1, 8'h5A);
    ahb(ADDR_STATUS, 1'b1, 8'h9D);
    tick(2);
    chk("direct not shared", 32'h0, {31'h0, directCommon});
    chk("indirect address", 32'h15A, {23'h0, indirectAddr});
    ahb(ADDR_PTR, 1'b1, 8'h0B);
    tick(2);
    chk("indirect shared", 32'h1, {31'h0, indirectCommon});
    chk("indirect high half", 32'h10B, {23'h0, indirectAddr});
    ahb(ADDR_STATUS, 1'b1, 8'hFD);
    core(OP_CLEAR, DEST_STATUS, 8'h00, 8'h00);
    chk("clear status", 32'h1D, {24'h0, statusOut});
    tick(2);
    chk("indirect low half", 32'h00B, {23'h0, indirectAddr});
    for (int i = 0; i < 12; i++) begin
      core(ops[i], DEST_NONE, opA[i], opB[i]);
      chk("flags", {24'h0, 5'h03, expFlg[i]}, {24'h0, statusOut});
      if (i < 11) chk("result", {24'h0, expRes[i]}, {24'h0, coreResult});
    end
    core(OP_ADD, DEST_STATUS, 8'hE0, 8'h01);
    chk("flag op to status", 32'hF8, {24'h0, statusOut});
    chk("result kept", 32'hE1, {24'h0, coreResult});
    core(OP_MOVE, DEST_STATUS, 8'h00, 8'h40);
    chk("move to status", 32'h58, {24'h0, statusOut});
    core(OP_MOVE, DEST_PTR, 8'h00, 8'h33);
    ahb(ADDR_PTR, 1'b0, 8'h00);
    chk("pointer by core", 32'h33, rd);
    pulse(3'b010);
    chk("after sleep", 32'h2, {30'h0, statusOut[4:3]});
    pulse(3'b001);
    chk("after timeout", 32'h0, {30'h0, statusOut[4:3]});
    ahb(ADDR_EVT, 1'b0, 8'h00);
    chk("power events", 32'h3, rd & 32'h3);
    chk("irq on event", 32'h1, {31'h0, irq});
    ahb(ADDR_EVTCLR, 1'b1, 8'h07);
    ahb(ADDR_EVT, 1'b0, 8'h00);
    chk("events cleared", 32'h0, rd);
    chk("irq dropped", 32'h0, {31'h0, irq});
    pulse(3'b100);
    chk("after kick", 32'h3, {30'h0, statusOut[4:3]});
    pulse(3'b010);
    @(posedge mclk);
    resetn <= 1'b0;
    #1;
    chk("status mid reset", 32'h18, {24'h0, statusOut});
    chk("ready mid reset", 32'h1, {31'h0, hreadyout});
    tick(2);
    resetn <= 1'b1;
    tick(2);
    chk("status after reset", 32'h18, {24'h0, statusOut});
    print_verdict();
  end
endmodule : csb_status_bank_bench
`default_nettype wire
